// [common/bkpt_emu_params.svh]
// Offsets, field positions, reset values and counts of the breakpoint/emulator block.
// Included by the package and by bkpt_emu_ctrl; definitions only.
`ifndef BKPT_EMU_PARAMS_SVH
`define BKPT_EMU_PARAMS_SVH

`define ADDR_W 5
`define CSR_IDX 5'h00
`define TDR_IDX 5'h07

`define CSR_BREAKPOINT_STATE_FIELD_HI 31
`define CSR_BREAKPOINT_STATE_FIELD_LO 28
`define CSR_COLLIDE_BIT 10
`define CSR_EMU_BIT 9
`define CSR_HALT_BIT 8
`define CSR_TRACE_BIT 6
`define CSR_MAP_BIT 5
`define CSR_FORCE_BIT 4
`define CSR_RESET 32'h0000_0000

`define TDR_RESP_HI 31
`define TDR_RESP_LO 30
`define TDR_L2EN_BIT 1
`define TDR_L1EN_BIT 0
`define TDR_RESET 32'h0000_0000

`define RESP_HALT 2'h1
`define RESP_DBG_IRQ 2'h2

`define DD_NONE 4'h0
`define DD_WAIT1 4'h2
`define DD_TRIG1 4'h4
`define DD_WAIT2 4'hA
`define DD_TRIG2 4'hC

`define PST_HALT 4'hF
`define PST_EMU_ENTRY 4'hD
`define PST_EMU_EXIT 4'h7

`define EXC_PST_CYCLES 3'h3
`define FRAME_LONGWORDS 3'h2
`define DBG_VECTOR 8'h0C

`define TT_EMU 2'h2
`define TM_EMU_DATA 3'h5
`define TM_EMU_CODE 3'h6

`define WR_DONE_STATUS 16'hFFFF

`endif

// [common/bkpt_emu_pkg.sv]
// Types shared by the breakpoint response / emulator-mode block.
// Assumes bkpt_emu_params.svh is on the include path.
package bkpt_emu_pkg;
  `include "bkpt_emu_params.svh"

  typedef enum logic [3:0] {
    BS_NONE  = 4'h0,
    BS_WAIT1 = 4'h1,
    BS_TRIG1 = 4'h2,
    BS_WAIT2 = 4'h5,
    BS_TRIG2 = 4'h6
  } breakpoint_state_field_t;

  typedef enum logic [1:0] {
    XS_IDLE  = 2'b00,
    XS_PST   = 2'b01,
    XS_FRAME = 2'b11,
    XS_VEC   = 2'b10
  } xseq_t;

  typedef enum logic [1:0] {
    BA_IDLE  = 2'b00,
    BA_STALL = 2'b01,
    BA_GRANT = 2'b11
  } barb_t;

  typedef struct packed {
    logic [1:0] tt;
    logic [2:0] tm;
  } xfer_attr_t;

  typedef struct packed {
    logic [`ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic [2:0] s;
    logic level;
  } sync_st_t;

  typedef struct packed {
    breakpoint_state_field_t breakpoint_state_field;
    logic [1:0] resp;
    logic l1_en;
    logic l2_en;
    logic force_emu;
    logic map;
    logic trace_emu;
    logic collide;
    logic arm;
    logic bus_pend;
    logic irq_pend;
    logic halted;
    logic emu;
    logic suppress;
    logic entry_pulse;
    logic exit_pulse;
    xseq_t xs;
    logic [2:0] xcnt;
    barb_t ba;
    logic [3:0] processor_status_port;
    logic [3:0] debug_data_port;
    xfer_attr_t attr;
    logic nocache;
    logic [2:0] irq_level;
    logic [31:0] rdata;
    logic wr_done;
    logic reject;
    logic exc_start;
    logic frame_wr;
    logic vec_fetch;
  } dbg_st_t;
endpackage

// [verilog/edge_sync3.sv]
// Three-stage synchroniser with edge report for slow pins.
// Assumes the pin is asynchronous to clock_i; a change is taken once stages 1 and 2 agree.
`timescale 1ns/1ps
module edge_sync3 (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic pin_i,
  input wire logic reset_level_i,
  output logic level_o,
  output logic rise_o,
  output logic fall_o
);
  import bkpt_emu_pkg::*;

  sync_st_t st_r;
  sync_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.s = {st_r.s[1:0], pin_i};
    // Stage 0 feeds only stage 1
    if (st_r.s[1] == st_r.s[2]) begin
      st_nxt.level = st_r.s[2];
    end
  end

  // Reset level is a tie-off, so the stages still load only constants
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign level_o = st_r.level ^ reset_level_i;
  assign rise_o = st_nxt.level & ~st_r.level & (st_r.s[1] == st_r.s[2]) ^ 1'b0;
  assign fall_o = ~st_nxt.level & st_r.level;
endmodule

// [verilog/bkpt_emu_ctrl.sv]
// Breakpoint trigger response and emulator-mode control of the debug module.
// Assumes a core that reports sample points, instruction completion, exceptions and bus idle,
// and a debug register port driven by the serial engine or the core's own debug write.
`timescale 1ns/1ps
`include "bkpt_emu_params.svh"
module bkpt_emu_ctrl (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire bkpt_emu_pkg::reg_req_t reg_req_i,
  input wire logic reg_from_core_i,
  output logic [31:0] reg_rdata_o,
  output logic reg_wr_done_o,
  output logic [15:0] reg_wr_status_o,
  input wire logic cmd_needs_halt_i,
  output logic cmd_reject_o,
  input wire logic debug_serial_clock_i,
  input wire logic reset_input_n_i,
  input wire logic pc_hit_i,
  input wire logic bus_hit_i,
  input wire logic sample_point_i,
  input wire logic insn_done_i,
  input wire logic return_from_exception_i,
  input wire logic trace_exc_i,
  input wire logic go_i,
  input wire logic [2:0] irq_level_i,
  output logic [2:0] irq_level_o,
  input wire logic [3:0] core_pst_i,
  output logic [3:0] processor_status_port_o,
  input wire logic capture_busy_i,
  input wire logic [3:0] capture_data_i,
  output logic [3:0] debug_data_port_o,
  input wire bkpt_emu_pkg::xfer_attr_t core_attr_i,
  input wire logic access_is_code_i,
  output bkpt_emu_pkg::xfer_attr_t bus_attr_o,
  output logic cache_sram_disable_o,
  output logic halt_o,
  output logic emu_mode_o,
  output logic exc_start_o,
  output logic frame_wr_o,
  output logic vec_fetch_o,
  output logic [7:0] vector_num_o,
  input wire logic bdm_mem_req_i,
  input wire logic bus_idle_i,
  input wire logic bdm_cycle_done_i,
  output logic fetch_stall_o,
  output logic bus_grant_o
);
  import bkpt_emu_pkg::*;

  dbg_st_t st_r;
  dbg_st_t st_nxt;

  logic sclk_level;
  logic sclk_rise;
  logic sclk_fall;
  logic rstin_level;
  logic rstin_rise;
  logic rstin_fall;

  logic csr_sel;
  logic tdr_sel;
  logic hit_now;
  logic triggered;
  logic take_irq;
  logic [31:0] csr_view;
  logic [31:0] tdr_view;

  edge_sync3 u_sclk_sync (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .pin_i(debug_serial_clock_i),
    .reset_level_i(1'b0),
    .level_o(sclk_level),
    .rise_o(sclk_rise),
    .fall_o(sclk_fall)
  );

  edge_sync3 u_rstin_sync (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .pin_i(reset_input_n_i),
    .reset_level_i(1'b0),
    .level_o(rstin_level),
    .rise_o(rstin_rise),
    .fall_o(rstin_fall)
  );

  function automatic logic [3:0] breakpoint_state_field_to_dd(input breakpoint_state_field_t b);
    logic [3:0] d;
    d = `DD_NONE;
    unique case (b)
      BS_NONE: d = `DD_NONE;
      BS_WAIT1: d = `DD_WAIT1;
      BS_TRIG1: d = `DD_TRIG1;
      BS_WAIT2: d = `DD_WAIT2;
      BS_TRIG2: d = `DD_TRIG2;
      default: d = `DD_NONE;
    endcase
    return d;
  endfunction

  always_comb begin
    csr_view = `CSR_RESET;
    csr_view[`CSR_BREAKPOINT_STATE_FIELD_HI:`CSR_BREAKPOINT_STATE_FIELD_LO] = st_r.breakpoint_state_field;
    csr_view[`CSR_COLLIDE_BIT] = st_r.collide;
    csr_view[`CSR_EMU_BIT] = st_r.emu;
    csr_view[`CSR_HALT_BIT] = st_r.halted;
    csr_view[`CSR_TRACE_BIT] = st_r.trace_emu;
    csr_view[`CSR_MAP_BIT] = st_r.map;
    csr_view[`CSR_FORCE_BIT] = st_r.force_emu;
    tdr_view = `TDR_RESET;
    tdr_view[`TDR_RESP_HI:`TDR_RESP_LO] = st_r.resp;
    tdr_view[`TDR_L2EN_BIT] = st_r.l2_en;
    tdr_view[`TDR_L1EN_BIT] = st_r.l1_en;
  end

  assign csr_sel = (reg_req_i.addr == `CSR_IDX);
  assign tdr_sel = (reg_req_i.addr == `TDR_IDX);
  // Bus hits count only at a sample point, PC hits are checked there too
  assign hit_now = sample_point_i & (pc_hit_i | bus_hit_i | st_r.bus_pend) & ~st_r.suppress;
  assign triggered = hit_now & ((st_r.breakpoint_state_field == BS_WAIT1 && !st_r.l2_en) || st_r.breakpoint_state_field == BS_WAIT2);
  // Debug interrupt outranks every level, so it is taken whatever irq_level_i shows
  assign take_irq = sample_point_i & st_r.irq_pend & ~st_r.emu & (st_r.xs == XS_IDLE);

  always_comb begin
    st_nxt = st_r;
    st_nxt.entry_pulse = 1'b0;
    st_nxt.exit_pulse = 1'b0;
    st_nxt.wr_done = 1'b0;
    st_nxt.reject = 1'b0;
    st_nxt.exc_start = 1'b0;
    st_nxt.frame_wr = 1'b0;
    st_nxt.vec_fetch = 1'b0;
    st_nxt.rdata = '0;

    // Software clear first, hardware events below override it
    if (reg_req_i.rd && csr_sel) begin
      st_nxt.rdata = csr_view;
      if (st_r.breakpoint_state_field == BS_TRIG2 || (st_r.breakpoint_state_field == BS_TRIG1 && !st_r.l2_en)) begin
        st_nxt.breakpoint_state_field = BS_NONE;
      end
      st_nxt.collide = 1'b0;
    end else if (reg_req_i.rd && tdr_sel) begin
      st_nxt.rdata = tdr_view;
    end

    if (reg_req_i.wr && csr_sel) begin
      st_nxt.force_emu = reg_req_i.wdata[`CSR_FORCE_BIT];
      st_nxt.map = reg_req_i.wdata[`CSR_MAP_BIT];
      st_nxt.trace_emu = reg_req_i.wdata[`CSR_TRACE_BIT];
    end
    if (reg_req_i.wr && tdr_sel) begin
      st_nxt.resp = reg_req_i.wdata[`TDR_RESP_HI:`TDR_RESP_LO];
      st_nxt.l2_en = reg_req_i.wdata[`TDR_L2EN_BIT];
      st_nxt.l1_en = reg_req_i.wdata[`TDR_L1EN_BIT];
      st_nxt.breakpoint_state_field = BS_NONE;
      st_nxt.arm = reg_req_i.wdata[`TDR_L1EN_BIT];
      st_nxt.bus_pend = 1'b0;
    end
    if (reg_req_i.wr) begin
      st_nxt.wr_done = 1'b1;
    end

    // Serial clock edges during a core-side read or write mean the host broke the quiet rule
    if (reg_from_core_i && (reg_req_i.wr || reg_req_i.rd) && (sclk_rise || sclk_fall)) begin
      st_nxt.collide = 1'b1;
    end

    if ((reg_req_i.wr || reg_req_i.rd) && cmd_needs_halt_i && !st_r.halted) begin
      st_nxt.reject = 1'b1;
    end

    // Arm one cycle after the clear so the cleared code is visible
    if (st_r.arm && !(reg_req_i.wr && tdr_sel)) begin
      st_nxt.arm = 1'b0;
      st_nxt.breakpoint_state_field = BS_WAIT1;
    end

    if (bus_hit_i && !st_r.suppress && (st_r.breakpoint_state_field == BS_WAIT1 || st_r.breakpoint_state_field == BS_WAIT2)) begin
      st_nxt.bus_pend = 1'b1;
    end
    if (hit_now) begin
      st_nxt.bus_pend = 1'b0;
      unique case (st_r.breakpoint_state_field)
        BS_WAIT1: st_nxt.breakpoint_state_field = st_r.l2_en ? BS_WAIT2 : BS_TRIG1;
        BS_WAIT2: st_nxt.breakpoint_state_field = BS_TRIG2;
        BS_NONE, BS_TRIG1, BS_TRIG2: st_nxt.breakpoint_state_field = st_r.breakpoint_state_field;
        default: st_nxt.breakpoint_state_field = BS_NONE;
      endcase
    end

    if (triggered && st_r.resp == `RESP_HALT) begin
      st_nxt.halted = 1'b1;
    end else if (go_i) begin
      st_nxt.halted = 1'b0;
    end
    if (triggered && st_r.resp == `RESP_DBG_IRQ) begin
      st_nxt.irq_pend = 1'b1;
    end

    // Debug exception: abort, status 0xD, frame, vector
    unique case (st_r.xs)
      XS_IDLE: begin
        if (take_irq) begin
          // A trigger in the same cycle stays pending: set wins over the take
          st_nxt.irq_pend = triggered && (st_r.resp == `RESP_DBG_IRQ);
          st_nxt.exc_start = 1'b1;
          st_nxt.emu = 1'b1;
          st_nxt.xcnt = `EXC_PST_CYCLES;
          st_nxt.xs = XS_PST;
        end
      end
      XS_PST: begin
        st_nxt.xcnt = st_r.xcnt - 3'h1;
        if (st_r.xcnt == 3'h1) begin
          st_nxt.xcnt = `FRAME_LONGWORDS;
          st_nxt.xs = XS_FRAME;
        end
      end
      XS_FRAME: begin
        st_nxt.frame_wr = 1'b1;
        st_nxt.xcnt = st_r.xcnt - 3'h1;
        if (st_r.xcnt == 3'h1) begin
          st_nxt.xs = XS_VEC;
        end
      end
      XS_VEC: begin
        st_nxt.vec_fetch = 1'b1;
        st_nxt.xs = XS_IDLE;
      end
    endcase

    if (rstin_rise && st_r.force_emu) begin
      st_nxt.emu = 1'b1;
      st_nxt.entry_pulse = 1'b1;
    end
    if (trace_exc_i && st_r.trace_emu && !st_r.emu) begin
      st_nxt.emu = 1'b1;
      st_nxt.entry_pulse = 1'b1;
    end
    if (return_from_exception_i && st_r.emu && st_r.xs == XS_IDLE) begin
      st_nxt.emu = 1'b0;
      st_nxt.exit_pulse = 1'b1;
      st_nxt.suppress = 1'b1;
    end else if (insn_done_i) begin
      st_nxt.suppress = 1'b0;
    end

    // Memory command arbitration on the local bus
    unique case (st_r.ba)
      BA_IDLE: if (bdm_mem_req_i) st_nxt.ba = BA_STALL;
      BA_STALL: if (bus_idle_i) st_nxt.ba = BA_GRANT;
      BA_GRANT: if (bdm_cycle_done_i) st_nxt.ba = BA_IDLE;
      default: st_nxt.ba = BA_IDLE;
    endcase

    if (st_r.halted) begin
      st_nxt.processor_status_port = `PST_HALT;
    end else if (st_r.xs != XS_IDLE || st_r.exc_start || st_r.entry_pulse) begin
      st_nxt.processor_status_port = `PST_EMU_ENTRY;
    end else if (st_r.exit_pulse) begin
      st_nxt.processor_status_port = `PST_EMU_EXIT;
    end else begin
      st_nxt.processor_status_port = core_pst_i;
    end

    st_nxt.debug_data_port = capture_busy_i ? capture_data_i : breakpoint_state_field_to_dd(st_r.breakpoint_state_field);

    st_nxt.irq_level = st_r.emu ? 3'h0 : irq_level_i;

    // Remap covers frame writes and the vector fetch as well
    st_nxt.nocache = st_nxt.emu & st_r.map;
    if (st_nxt.emu && st_r.map) begin
      st_nxt.attr.tt = `TT_EMU;
      st_nxt.attr.tm = access_is_code_i ? `TM_EMU_CODE : `TM_EMU_DATA;
    end else begin
      st_nxt.attr = core_attr_i;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata_o = st_r.rdata;
  assign reg_wr_done_o = st_r.wr_done;
  assign reg_wr_status_o = st_r.wr_done ? `WR_DONE_STATUS : 16'h0000;
  assign cmd_reject_o = st_r.reject;
  assign irq_level_o = st_r.irq_level;
  assign processor_status_port_o = st_r.processor_status_port;
  assign debug_data_port_o = st_r.debug_data_port;
  assign bus_attr_o = st_r.attr;
  assign cache_sram_disable_o = st_r.nocache;
  assign halt_o = st_r.halted;
  assign emu_mode_o = st_r.emu;
  assign exc_start_o = st_r.exc_start;
  assign frame_wr_o = st_r.frame_wr;
  assign vec_fetch_o = st_r.vec_fetch;
  assign vector_num_o = `DBG_VECTOR;
  assign fetch_stall_o = (st_r.ba != BA_IDLE);
  assign bus_grant_o = (st_r.ba == BA_GRANT);
endmodule

// [dv/bkpt_emu_chk.sv]
// Port-level checker for the breakpoint response / emulator-mode block.
// Assumes the design top bkpt_emu_ctrl; bound by name below.
`timescale 1ns/1ps
module bkpt_emu_chk (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire bkpt_emu_pkg::reg_req_t reg_req_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic reg_wr_done_o,
  input wire logic [15:0] reg_wr_status_o,
  input wire logic capture_busy_i,
  input wire logic [3:0] debug_data_port_o,
  input wire logic [3:0] processor_status_port_o,
  input wire logic halt_o,
  input wire logic emu_mode_o,
  input wire logic [2:0] irq_level_o,
  input wire logic exc_start_o,
  input wire logic frame_wr_o,
  input wire logic cache_sram_disable_o,
  input wire bkpt_emu_pkg::xfer_attr_t bus_attr_o,
  input wire logic bus_idle_i,
  input wire logic bdm_cycle_done_i,
  input wire logic fetch_stall_o,
  input wire logic bus_grant_o
);
  import bkpt_emu_pkg::*;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  sequence s_entry;
    ##[0:2] emu_mode_o ##[0:3] processor_status_port_o == 4'hD;
  endsequence
  sequence s_two_longwords;
    frame_wr_o ##1 !frame_wr_o;
  endsequence
  property p_wr_done;
    reg_req_i.wr |=> reg_wr_done_o && reg_wr_status_o == 16'hFFFF;
  endproperty
  property p_rd_state;
    $past(reg_req_i.rd && reg_req_i.addr == 5'h00)
      |-> reg_rdata_o[31:28] inside {4'h0, 4'h1, 4'h2, 4'h5, 4'h6};
  endproperty
  // Capture data takes the port for a cycle after busy drops
  property p_dd_legal;
    !capture_busy_i && !$past(capture_busy_i) && !$past(capture_busy_i, 2)
      |-> debug_data_port_o inside {4'h0, 4'h2, 4'h4, 4'hA, 4'hC};
  endproperty
  property p_halt_pst;
    $rose(halt_o) |=> processor_status_port_o == 4'hF;
  endproperty
  property p_emu_irq;
    emu_mode_o && $past(emu_mode_o) |-> irq_level_o == 3'h0;
  endproperty
  property p_exc;
    exc_start_o |-> s_entry;
  endproperty
  property p_frame;
    $rose(frame_wr_o) |=> s_two_longwords;
  endproperty
  property p_exit;
    $fell(emu_mode_o) |-> ##[0:2] processor_status_port_o == 4'h7;
  endproperty
  property p_map;
    cache_sram_disable_o && $past(cache_sram_disable_o)
      |-> bus_attr_o.tt == 2'h2 && bus_attr_o.tm inside {3'h5, 3'h6};
  endproperty
  property p_grant;
    fetch_stall_o && bus_idle_i && !bus_grant_o |=> bus_grant_o;
  endproperty
  property p_release;
    bus_grant_o && bdm_cycle_done_i |=> !bus_grant_o && !fetch_stall_o;
  endproperty
  a_wr_done: assert property (p_wr_done) else $error("write completion wrong");
  a_rd_state: assert property (p_rd_state) else $error("bad state code read");
  a_dd_legal: assert property (p_dd_legal) else $error("bad debug data code");
  a_halt_pst: assert property (p_halt_pst) else $error("halt status missing");
  a_emu_irq: assert property (p_emu_irq) else $error("irq passed in emulator");
  a_exc: assert property (p_exc) else $error("exception entry wrong");
  a_frame: assert property (p_frame) else $error("frame length wrong");
  a_exit: assert property (p_exit) else $error("exit status missing");
  a_map: assert property (p_map) else $error("remap attribute wrong");
  a_grant: assert property (p_grant) else $error("grant late");
  a_release: assert property (p_release) else $error("bus not reclaimed");
endmodule

bind bkpt_emu_ctrl bkpt_emu_chk chk_u (.clock_i(clock_i), .nrst_i(nrst_i),
  .reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o), .reg_wr_done_o(reg_wr_done_o),
  .reg_wr_status_o(reg_wr_status_o), .capture_busy_i(capture_busy_i),
  .debug_data_port_o(debug_data_port_o), .processor_status_port_o(processor_status_port_o),
  .halt_o(halt_o), .emu_mode_o(emu_mode_o), .irq_level_o(irq_level_o),
  .exc_start_o(exc_start_o), .frame_wr_o(frame_wr_o),
  .cache_sram_disable_o(cache_sram_disable_o), .bus_attr_o(bus_attr_o),
  .bus_idle_i(bus_idle_i), .bdm_cycle_done_i(bdm_cycle_done_i),
  .fetch_stall_o(fetch_stall_o), .bus_grant_o(bus_grant_o));

// [dv/dev_link_model.sv]
// Development-system end of the serial debug link: its serial clock.
// Assumes the bench frames traffic; phase is unrelated to the core clock.
`timescale 1ns/1ps
module dev_link_model (
  input wire logic frame_i,
  output logic debug_serial_clock_o
);
  initial begin
    debug_serial_clock_o = 1'h0;
    #13;
    forever begin
      #40;
      if (frame_i) begin
        debug_serial_clock_o = ~debug_serial_clock_o;
      end else begin
        debug_serial_clock_o = 1'h0;
      end
    end
  end
endmodule

// [dv/test_bkpt_emu_ctrl.sv]
// Self-checking bench for the breakpoint response / emulator-mode block.
// Assumes the checker is bound in and the link model makes the serial clock.
`timescale 1ns/1ps
module test_bkpt_emu_ctrl;
  import bkpt_emu_pkg::*;
  logic clock_i, nrst_i, fc, nh, rstp, pch, bsh, sp, idn, return_from_exception, trc, go, busy, isc;
  logic mreq, bidl, cdone, frame, rd_seen, wr_seen;
  logic wdn, rej, halt, emu, exc, fwr, vec, ncache, stall, grant;
  reg_req_t req;
  xfer_attr_t attr, battr;
  logic [2:0] irq, irqo;
  logic [3:0] cpst, cap, processor_status_port, dd;
  logic [4:0] ua;
  logic [7:0] vnum;
  logic [15:0] wst;
  logic [31:0] rdata;
  logic [31:0] exp_q[$];
  wire sclk;
  int failures, n_compared;

  bkpt_emu_ctrl dut_u (.clock_i(clock_i), .nrst_i(nrst_i), .reg_req_i(req),
    .reg_from_core_i(fc), .reg_rdata_o(rdata), .reg_wr_done_o(wdn), .reg_wr_status_o(wst),
    .cmd_needs_halt_i(nh), .cmd_reject_o(rej), .debug_serial_clock_i(sclk),
    .reset_input_n_i(rstp), .pc_hit_i(pch), .bus_hit_i(bsh), .sample_point_i(sp),
    .insn_done_i(idn), .return_from_exception_i(return_from_exception), .trace_exc_i(trc), .go_i(go),
    .irq_level_i(irq), .irq_level_o(irqo), .core_pst_i(cpst), .processor_status_port_o(processor_status_port),
    .capture_busy_i(busy), .capture_data_i(cap), .debug_data_port_o(dd),
    .core_attr_i(attr), .access_is_code_i(isc), .bus_attr_o(battr),
    .cache_sram_disable_o(ncache), .halt_o(halt), .emu_mode_o(emu), .exc_start_o(exc),
    .frame_wr_o(fwr), .vec_fetch_o(vec), .vector_num_o(vnum), .bdm_mem_req_i(mreq),
    .bus_idle_i(bidl), .bdm_cycle_done_i(cdone), .fetch_stall_o(stall), .bus_grant_o(grant));
  dev_link_model link_u (.frame_i(frame), .debug_serial_clock_o(sclk));

  initial begin
    clock_i = 1'h0;
    forever #2.5 clock_i = ~clock_i;
  end

  task automatic give_verdict();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask

  // Read data stands only in the cycle after the strobe
  always @(posedge clock_i) begin
    rd_seen <= req.rd;
    wr_seen <= req.wr;
  end
  always @(negedge clock_i) begin
    if (rd_seen === 1'h1) begin
      if (exp_q.size() == 0)
        chk(rdata, 32'hDEAD_BEEF);
      else
        chk(rdata, exp_q.pop_front());
    end
    if (wr_seen === 1'h1)
      chk({15'h0, wdn, wst}, 32'h0001_FFFF);
  end

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clock_i);
    req <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
    @(posedge clock_i);
    req.wr <= 1'h0;
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    @(posedge clock_i);
    req.addr <= a;
    req.rd <= 1'h1;
    @(posedge clock_i);
    req.rd <= 1'h0;
  endtask

  task automatic smp(input logic p);
    @(posedge clock_i);
    sp <= 1'h1;
    pch <= p;
    @(posedge clock_i);
    sp <= 1'h0;
    pch <= 1'h0;
  endtask

  task automatic stb(input int k);
    @(posedge clock_i);
    case (k)
      0: go <= 1'h1;
      1: return_from_exception <= 1'h1;
      2: bsh <= 1'h1;
      4: trc <= 1'h1;
      default: idn <= 1'h1;
    endcase
    @(posedge clock_i);
    trc <= 1'h0;
    go <= 1'h0;
    return_from_exception <= 1'h0;
    bsh <= 1'h0;
    idn <= 1'h0;
  endtask

  function automatic logic sig(input int s);
    case (s)
      0: return halt;
      1: return exc;
      2: return grant;
      3: return emu;
      4: return vec;
      6: return sclk;
      default: return !emu;
    endcase
  endfunction

  task automatic wt(input int s);
    int n;
    n = 0;
    do begin
      @(negedge clock_i);
      n++;
    end while (sig(s) !== 1'h1 && n < 60);
    n_compared++;
    if (n >= 60) begin
      failures++;
      $display("MISMATCH t=%0t wait %0h exp %0h", $time, s, 1);
      give_verdict();
    end
  endtask

  initial begin
    {nrst_i, fc, nh, rstp, pch, bsh, sp, idn, return_from_exception, trc, go, busy, isc} = '0;
    {mreq, bidl, cdone, frame, rd_seen, wr_seen} = '0;
    req = '0;
    attr = '0;
    irq = 3'h0;
    cap = 4'h0;
    cpst = 4'h1;
    failures = 0;
    n_compared = 0;
    void'($urandom(1));
    repeat (12) @(posedge clock_i);
    nrst_i <= 1'h1;
    repeat (4) @(posedge clock_i);
    rd(5'h00, 32'h0000_0000);
    wr(5'h00, 32'h0000_0030);
    rstp <= 1'h1;
    wt(3);
    @(posedge clock_i);
    attr <= xfer_attr_t'($urandom);
    isc <= 1'h1;
    repeat (3) @(negedge clock_i);
    chk(32'({ncache, battr}), 32'h0000_0036);
    @(posedge clock_i);
    isc <= 1'h0;
    repeat (3) @(negedge clock_i);
    chk(32'({ncache, battr}), 32'h0000_0035);
    stb(1);
    wt(5);
    stb(3);
    wr(5'h00, 32'h0000_0040);
    stb(4);
    wt(3);
    rd(5'h00, 32'h0000_0240);
    stb(1);
    wt(5);
    stb(3);
    wr(5'h00, 32'h0000_0000);
    // Halt response, level-1 only
    wr(5'h07, 32'h4000_0001);
    rd(5'h00, 32'h1000_0000);
    @(negedge clock_i);
    chk(32'(dd), 32'h0000_0002);
    smp(1'h1);
    wt(0);
    @(negedge clock_i);
    chk(32'({processor_status_port, dd}), 32'h0000_00F4);
    @(posedge clock_i);
    busy <= 1'h1;
    cap <= 4'h9;
    repeat (3) @(negedge clock_i);
    chk(32'(dd), 32'h0000_0009);
    @(posedge clock_i);
    busy <= 1'h0;
    rd(5'h00, 32'h2000_0100);
    nh <= 1'h1;
    rd(5'h00, 32'h0000_0100);
    @(negedge clock_i);
    chk(32'(rej), 32'h0000_0000);
    stb(0);
    ua = 5'($urandom_range(31, 8));
    wr(ua, $urandom);
    nh <= 1'h0;
    @(negedge clock_i);
    chk(32'(rej), 32'h0000_0001);
    rd(ua, 32'h0000_0000);
    // Debug interrupt through two levels, level-7 request present
    irq <= 3'h7;
    wr(5'h07, 32'h0000_0000);
    wr(5'h07, 32'h8000_0003);
    smp(1'h1);
    rd(5'h00, 32'h5000_0000);
    stb(2);
    smp(1'h0);
    smp(1'h0);
    wt(1);
    wt(4);
    chk(32'({irqo, vnum}), 32'h0000_000C);
    rd(5'h00, 32'h6000_0200);
    rd(5'h00, 32'h0000_0200);
    wr(5'h07, 32'h8000_0001);
    stb(1);
    wt(5);
    smp(1'h1);
    rd(5'h00, 32'h1000_0000);
    chk(32'(irqo), 32'h0000_0007);
    stb(3);
    smp(1'h1);
    rd(5'h00, 32'h2000_0000);
    wr(5'h07, 32'h0000_0000);
    // Debug memory access takes the local bus
    mreq <= 1'h1;
    repeat (2) @(negedge clock_i);
    chk(32'({stall, grant}), 32'h0000_0002);
    @(posedge clock_i);
    bidl <= 1'h1;
    wt(2);
    @(posedge clock_i);
    cdone <= 1'h1;
    mreq <= 1'h0;
    @(posedge clock_i);
    cdone <= 1'h0;
    @(negedge clock_i);
    chk(32'({stall, grant}), 32'h0000_0000);
    // Core-side write while the serial clock runs
    @(posedge clock_i);
    frame <= 1'h1;
    fc <= 1'h1;
    // Strobe lands in the cycle the synchronised first serial clock edge shows
    wt(6);
    repeat (2) @(posedge clock_i);
    wr(5'h00, 32'h0000_0000);
    frame <= 1'h0;
    fc <= 1'h0;
    rd(5'h00, 32'h0000_0400);
    rd(5'h00, 32'h0000_0000);
    repeat (5) @(posedge clock_i);
    give_verdict();
  end
endmodule
